// *** core/tmr1_pkg.sv ***
// Package for timer one control and prescale block
// Assumes an APB slave with 32-bit data and byte addressing
`default_nettype none
package tmr1_pkg;
	localparam logic [11:0] TMR1_CTRL_OFS   = 12'h0f2;
	localparam logic [11:0] TMR1_DIV_OFS    = 12'h0f3;
	localparam logic [11:0] TMR1_CTRL_ADDR  = 12'h3c8;
	localparam logic [11:0] TMR1_DIV_ADDR   = 12'h3cc;
	localparam logic [11:0] TMR1_CNT_ADDR   = 12'h3d0;
	localparam logic [11:0] TMR1_EVT_ADDR   = 12'h3d4;
	localparam logic [11:0] TMR1_ISTAT_ADDR = 12'h3d8;
	localparam logic [11:0] TMR1_IMASK_ADDR = 12'h3dc;
	localparam int          TMR1_MODE_HI    = 7;
	localparam int          TMR1_MODE_LO    = 6;
	localparam int          TMR1_CLR_BIT    = 5;
	localparam int          TMR1_RUN_BIT    = 4;
	localparam int          TMR1_MIE_BIT    = 3;
	localparam int          TMR1_OIE_BIT    = 2;
	localparam int          TMR1_MPND_BIT   = 1;
	localparam int          TMR1_OPND_BIT   = 0;
	localparam int          TMR1_SRC_BIT    = 7;
	localparam logic [7:0]  TMR1_CTRL_RST   = 8'h00;
	localparam logic [3:0]  TMR1_PS_RST     = 4'h0;
	localparam logic [3:0]  TMR1_PS_MAX     = 4'hc;
	localparam logic [1:0]  TMR1_EVT_RST    = 2'h0;
	localparam int          TMR1_SYNC_STG   = 2;
	typedef enum logic [1:0] {
		TMR1_INTERVAL,
		TMR1_CAP_RISE,
		TMR1_CAP_FALL,
		TMR1_PWM
	} tmr1_mode_t;
	typedef struct packed {
		logic [11:0] addr;
		logic        write;
		logic [31:0] wdata;
	} tmr1_req_t;
endpackage
`default_nettype wire

// *** core/tmr1_div.sv ***
// Power-of-two clock divider producing one-cycle count ticks
// Assumes the source tick is one cycle wide and synchronous to pclk
`default_nettype none
module tmr1_div
	import tmr1_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       src_tick,
	input  wire logic       clear,
	input  wire logic [3:0] ps_sel,
	output logic            tick
);
	logic [11:0] cnt_q;
	logic [12:0] mask;

	assign mask = (13'h0001 << ps_sel) - 13'h0001;
	assign tick = src_tick & ((cnt_q & mask[11:0]) == mask[11:0]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 12'h000;
		end else if (clear) begin
			cnt_q <= 12'h000;
		end else if (src_tick) begin
			cnt_q <= cnt_q + 12'h001;
		end
	end
endmodule
`default_nettype wire

// *** core/tmr1_ctrl.sv ***
// Timer one control, prescaler and interrupt registers over APB
// Assumes external clock pin synchronous to pclk; capture input likewise
//
// Our own choice: the APB register port.
`default_nettype none
module tmr1_ctrl
	import tmr1_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timer_one_external_clock_pin,
	input  wire logic        capture_in,
	input  wire logic [7:0]  match_value,
	output logic [7:0]       count_value,
	output tmr1_mode_t       mode,
	output logic             irq
);
	tmr1_req_t   req;
	logic        wr_en;
	logic        rd_en;
	logic        hit;
	logic [7:0]  ctrl_q;
	logic [7:2]  cfg_q;
	logic [1:0]  pnd_q;
	logic        src_q;
	logic [3:0]  ps_q;
	logic [7:0]  cnt_q;
	logic [1:0]  ist_q;
	logic [1:0]  imask_q;
	logic        ext_q;
	logic        cap_q;
	logic        src_tick;
	logic        tick;
	logic        clr_pulse;
	logic        cap_evt;
	logic        match_evt;
	logic        ovf_evt;
	logic [7:0]  cap_q8;
	logic [31:0] rdata_d;

	////////////////////////////////////////////////////////////////
	// APB decode
	assign req     = '{addr: paddr, write: pwrite, wdata: pwdata};
	assign pready  = 1'b1;
	assign wr_en   = psel & penable & req.write;
	assign rd_en   = psel & penable & ~req.write;
	assign hit     = (req.addr == TMR1_CTRL_ADDR) | (req.addr == TMR1_DIV_ADDR) |
	                 (req.addr == TMR1_CNT_ADDR) | (req.addr == TMR1_EVT_ADDR) |
	                 (req.addr == TMR1_ISTAT_ADDR) | (req.addr == TMR1_IMASK_ADDR);
	assign pslverr = psel & penable & ~hit;
	assign clr_pulse = wr_en & (req.addr == TMR1_CTRL_ADDR) & req.wdata[TMR1_CLR_BIT];
	assign mode = tmr1_mode_t'(ctrl_q[TMR1_MODE_HI:TMR1_MODE_LO]);
	assign count_value = cnt_q;

	////////////////////////////////////////////////////////////////
	// Control register
	assign ctrl_q = {cfg_q, pnd_q};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= TMR1_CTRL_RST[7:2];
		end else if (wr_en && req.addr == TMR1_CTRL_ADDR) begin
			cfg_q[7:6] <= req.wdata[7:6];
			cfg_q[5]   <= 1'b0;
			cfg_q[4:2] <= req.wdata[4:2];
		end
	end

	// pending set wins, clear by zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pnd_q <= TMR1_EVT_RST;
		end else begin
			pnd_q[TMR1_MPND_BIT] <= match_evt | (pnd_q[TMR1_MPND_BIT] &
				~(wr_en && req.addr == TMR1_CTRL_ADDR && !req.wdata[TMR1_MPND_BIT]));
			pnd_q[TMR1_OPND_BIT] <= ovf_evt | (pnd_q[TMR1_OPND_BIT] &
				~(wr_en && req.addr == TMR1_CTRL_ADDR && !req.wdata[TMR1_OPND_BIT]));
		end
	end

	// Prescaler register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q <= 1'b0;
			ps_q  <= TMR1_PS_RST;
		end else if (wr_en && req.addr == TMR1_DIV_ADDR) begin
			src_q <= req.wdata[TMR1_SRC_BIT];
			// Out-of-range ratios clamp
			ps_q  <= (req.wdata[3:0] > TMR1_PS_MAX) ? TMR1_PS_MAX : req.wdata[3:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Clock source and divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_q <= 1'b0;
			cap_q <= 1'b0;
		end else begin
			ext_q <= timer_one_external_clock_pin;
			cap_q <= capture_in;
		end
	end

	assign src_tick = src_q ? (timer_one_external_clock_pin & ~ext_q) : 1'b1;

	tmr1_div u_div (
		.pclk     (pclk),
		.presetn  (presetn),
		.src_tick (src_tick),
		.clear    (clr_pulse),
		.ps_sel   (ps_q),
		.tick     (tick)
	);

	////////////////////////////////////////////////////////////////
	// Counter
	// run gating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 8'h00;
		end else if (clr_pulse) begin
			cnt_q <= 8'h00;
		end else if (ctrl_q[TMR1_RUN_BIT] && tick) begin
			if (mode == TMR1_INTERVAL && cnt_q == match_value) begin
				cnt_q <= 8'h00;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	assign cap_evt = ((mode == TMR1_CAP_RISE) & capture_in & ~cap_q) |
	                 ((mode == TMR1_CAP_FALL) & ~capture_in & cap_q);
	assign match_evt = cap_evt |
		(ctrl_q[TMR1_RUN_BIT] & tick & (mode == TMR1_INTERVAL || mode == TMR1_PWM) & (cnt_q == match_value));
	assign ovf_evt = ctrl_q[TMR1_RUN_BIT] & tick & (cnt_q == 8'hff) & (mode != TMR1_INTERVAL);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_q8 <= 8'h00;
		end else if (cap_evt) begin
			cap_q8 <= cnt_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt status and mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist_q   <= TMR1_EVT_RST;
			imask_q <= TMR1_EVT_RST;
		end else begin
			ist_q <= {match_evt, ovf_evt} |
				(ist_q & ~((wr_en && req.addr == TMR1_ISTAT_ADDR) ? req.wdata[1:0] : 2'h0));
			if (wr_en && req.addr == TMR1_IMASK_ADDR) begin
				imask_q <= req.wdata[1:0];
			end
		end
	end

	assign irq = |(ist_q & imask_q & {ctrl_q[TMR1_MIE_BIT], ctrl_q[TMR1_OIE_BIT]});

	////////////////////////////////////////////////////////////////
	// Read data
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (req.addr)
			TMR1_CTRL_ADDR:  rdata_d = {24'h000000, ctrl_q};
			TMR1_DIV_ADDR:   rdata_d = {24'h000000, src_q, 3'h0, ps_q};
			TMR1_CNT_ADDR:   rdata_d = {24'h000000, cnt_q};
			TMR1_EVT_ADDR:   rdata_d = {24'h000000, cap_q8};
			TMR1_ISTAT_ADDR: rdata_d = {30'h00000000, ist_q};
			TMR1_IMASK_ADDR: rdata_d = {30'h00000000, imask_q};
			default:         rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rdata_d;
		end
	end

	logic unused_rd;
	assign unused_rd = rd_en;
endmodule
`default_nettype wire

// *** verification/tmr1_monitor.sv ***
// Checker for the timer one control block
// Assumes a bind onto the tmr1_ctrl ports
`default_nettype none
module tmr1_monitor
	import tmr1_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [7:0]  count_value,
	input wire tmr1_mode_t  mode,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic wc = psel && penable && pwrite && paddr == TMR1_CTRL_ADDR;
	wire logic wm = psel && penable && pwrite && paddr == TMR1_IMASK_ADDR;
	AST_MODE: assert property (wc |=> mode == $past(pwdata[7:6])) else $error("mode");
	AST_CLR: assert property (wc && pwdata[5] |-> ##[1:2] count_value == 8'h00) else $error("clear");
	AST_HALT: assert property (wc && !pwdata[5] && !pwdata[4] |=> ##1 $stable(count_value) [*8]) else $error("halt");
	AST_STEP: assert property ($changed(count_value) && count_value != 8'h00
		|-> count_value == $past(count_value) + 8'h01) else $error("step");
	AST_MASK: assert property (wm && pwdata[1:0] == 2'h0 |=> !irq) else $error("mask");
	AST_ENA: assert property (wc && pwdata[3:2] == 2'h0 |=> !irq) else $error("enable");
endmodule
`default_nettype wire

// *** verification/tmr1_ext_clk.sv ***
// Model of the external clock pin source
// Assumes pclk from the bench; pin idles low
`default_nettype none
module tmr1_ext_clk (
	input  wire logic pclk,
	output logic      pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pin = 1'h0;
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge pclk);
			pin <= 1'h1;
			repeat (2) @(posedge pclk);
			pin <= 1'h0;
			repeat (2) @(posedge pclk);
		end
	endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Top bench for the timer one control block
// Assumes package, design, pin model and checker compiled first
`default_nettype none
module tb_top
	import tmr1_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e;} tmr1_row_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, irq, cap, se;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  count_value, c0;
	tmr1_mode_t  mode;
	int          err_total, samples_checked;
	tmr1_row_t   rows [8] = '{'{1'h0, TMR1_CTRL_ADDR, 8'h00, 8'h00}, '{1'h0, TMR1_DIV_ADDR, 8'h00, 8'h00},
		'{1'h1, TMR1_CTRL_ADDR, 8'h40, 8'h40}, '{1'h1, TMR1_CTRL_ADDR, 8'h80, 8'h80},
		'{1'h1, TMR1_CTRL_ADDR, 8'hc0, 8'hc0}, '{1'h1, TMR1_CTRL_ADDR, 8'h2c, 8'h0c},
		'{1'h1, TMR1_DIV_ADDR, 8'h8f, 8'h8c}, '{1'h1, 12'h3e0, 8'h11, 8'h00}};
	tmr1_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_one_external_clock_pin(pin), .capture_in(cap), .match_value(8'hff),
		.count_value(count_value), .mode(mode), .irq(irq));
	tmr1_ext_clk ext (.pclk(pclk), .pin(pin));
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cnt(input string n, input logic [7:0] e);
		repeat (3) @(posedge pclk);
		#1 chk(n, {24'h0, e}, {24'h0, count_value});
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			err_total++;
			tally_and_finish();
		end
		rd = prdata;
		se = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, cap} = '0;
		err_total = 0;
		samples_checked = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		foreach (rows[i]) begin
			if (rows[i].w) apb(1'h1, rows[i].a, {24'h0, rows[i].d});
			apb(1'h0, rows[i].a, 32'h0);
			chk("reg", {24'h0, rows[i].e}, rd);
			chk("slverr", {31'h0, rows[i].a == 12'h3e0}, {31'h0, se});
		end
		$display("register test done");
		apb(1'h1, TMR1_DIV_ADDR, 32'h80);
		apb(1'h1, TMR1_CTRL_ADDR, 32'h20);
		cnt("cleared", 8'h00);
		apb(1'h1, TMR1_CTRL_ADDR, 32'h10);
		ext.pulse(5);
		cnt("ext run", 8'h05);
		apb(1'h1, TMR1_CTRL_ADDR, 32'h00);
		ext.pulse(3);
		cnt("ext stop", 8'h05);
		$display("external test done");
		apb(1'h1, TMR1_DIV_ADDR, 32'h02);
		apb(1'h1, TMR1_CTRL_ADDR, 32'h10);
		repeat (5) @(posedge pclk);
		#1 c0 = count_value;
		repeat (29) @(posedge pclk);
		cnt("div4", c0 + 8'h08);
		$display("divider test done");
		apb(1'h1, TMR1_DIV_ADDR, 32'h00);
		apb(1'h1, TMR1_IMASK_ADDR, 32'h01);
		apb(1'h1, TMR1_CTRL_ADDR, 32'hd4);
		for (int i = 0; i < 600 && irq !== 1'h1; i++) @(posedge pclk);
		chk("irq set", 32'h1, {31'h0, irq});
		if (irq !== 1'h1) tally_and_finish();
		apb(1'h1, TMR1_IMASK_ADDR, 32'h00);
		#1 chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'h1, TMR1_IMASK_ADDR, 32'h01);
		#1 chk("irq unmasked", 32'h1, {31'h0, irq});
		apb(1'h1, TMR1_CTRL_ADDR, 32'hc4);
		apb(1'h1, TMR1_ISTAT_ADDR, 32'h03);
		#1 chk("irq cleared", 32'h0, {31'h0, irq});
		$display("interrupt test done");
		apb(1'h1, TMR1_CTRL_ADDR, 32'h48);
		apb(1'h0, TMR1_CNT_ADDR, 32'h0);
		c0 = rd[7:0];
		cap <= 1'h1;
		apb(1'h0, TMR1_EVT_ADDR, 32'h0);
		chk("capture rise", {24'h0, c0}, rd);
		apb(1'h0, TMR1_ISTAT_ADDR, 32'h0);
		chk("rise flag", 32'h2, rd);
		apb(1'h0, TMR1_CTRL_ADDR, 32'h0);
		chk("rise pend", 32'h4a, rd);
		apb(1'h1, TMR1_ISTAT_ADDR, 32'h03);
		apb(1'h1, TMR1_CTRL_ADDR, 32'h80);
		cap <= 1'h0;
		apb(1'h0, TMR1_ISTAT_ADDR, 32'h0);
		chk("fall flag", 32'h2, rd);
		$display("capture test done");
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, TMR1_CTRL_ADDR, 32'h0);
		chk("reset ctrl", 32'h0, rd);
		apb(1'h0, TMR1_DIV_ADDR, 32'h0);
		chk("reset div", 32'h0, rd);
		$display("reset test done");
		tally_and_finish();
	end
endmodule
bind tmr1_ctrl tmr1_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .count_value(count_value), .mode(mode), .irq(irq));
`default_nettype wire
